// [core/fsrrc_pkg.sv]
package fsrrc_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_PROG   = 3'b001,
        ST_ERASE  = 3'b010,
        ST_PSUSP  = 3'b011,
        ST_ESUSP  = 3'b100,
        ST_PP_ES  = 3'b101,
        ST_STATUS = 3'b110
    } fsrrc_state_t;

    // Operation kinds requested by the array decoder
    typedef enum logic [2:0] {
        OP_PROG   = 3'b000,
        OP_SECTOR = 3'b001,
        OP_BLOCK  = 3'b010,
        OP_CHIP   = 3'b011,
        OP_STATUS = 3'b100
    } fsrrc_op_t;

    typedef struct packed {
        logic erase_suspend_flag;
        logic program_suspend_flag;
        logic write_enable_latch;
        logic busy_flag;
    } fsrrc_flags_t;

    typedef logic [21:0] fsrrc_rec_t;

    localparam fsrrc_flags_t FLAGS_RESET = 4'h0;
    localparam int SEC_PSB_BIT = 2;
    localparam int SEC_ESB_BIT = 3;

    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_RESET_ARM = 8'h66;
    localparam logic [7:0] CMD_RESET = 8'h99;
    localparam logic [7:0] CMD_RESUME_A = 8'h7A;
    localparam logic [7:0] CMD_RESUME_B = 8'h30;
    localparam logic [7:0] CMD_PARAM_READ = 8'h5A;

    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_ADDR_END = 6'h20;
    localparam logic [5:0] BITS_DATA = 6'h28;
    localparam logic [5:0] STEP_SERIAL = 6'h01;
    localparam logic [5:0] STEP_QUAD = 6'h04;

    // Clock rate and times
    localparam int CLK_KHZ = 25000;
    localparam int RESET_LOW_WIDTH_US = 10;
    localparam int POWER_RESET_RECOVERY_US = 35;
    localparam int REC_DECODE_US = 40;
    localparam int REC_READ_US = 35;
    localparam int REC_PROG_US = 310;
    localparam int REC_SECTOR_MS = 12;
    localparam int REC_BLOCK_MS = 25;
    localparam int REC_CHIP_MS = 100;
    localparam int REC_STATUS_MS = 40;

    localparam logic [7:0] RST_LOW_CYC = 8'((RESET_LOW_WIDTH_US * CLK_KHZ + 999) / 1000);
    localparam fsrrc_rec_t POR_REC_CYC =
        fsrrc_rec_t'((POWER_RESET_RECOVERY_US * CLK_KHZ + 999) / 1000);
    localparam fsrrc_rec_t DECODE_REC_CYC = fsrrc_rec_t'((REC_DECODE_US * CLK_KHZ + 999) / 1000);
    localparam fsrrc_rec_t READ_REC_CYC = fsrrc_rec_t'((REC_READ_US * CLK_KHZ + 999) / 1000);
    localparam int PROG_REC_CYC = (REC_PROG_US * CLK_KHZ + 999) / 1000;
    localparam int SECTOR_REC_CYC = REC_SECTOR_MS * CLK_KHZ;
    localparam int BLOCK_REC_CYC = REC_BLOCK_MS * CLK_KHZ;
    localparam int CHIP_REC_CYC = REC_CHIP_MS * CLK_KHZ;
    localparam int STATUS_REC_CYC = REC_STATUS_MS * CLK_KHZ;

endpackage

// [core/fsrrc_ctrl.sv]
// Contract
// (R1) Listed status, reset and no-operation commands act at once while suspended.
// (R2) Erase suspend allows page program except in the suspended region.
// (R3) Host sends write enable before every page program.
// (R4) Program started inside erase suspend cannot be suspended.
// (R5) That program holds latch and busy high, clears both when done.
// (R6) Resume continues the suspended program or erase.
// (R7) Host checks no program runs before resuming an erase.
// (R8) Resume sets latch and busy, clears the matching suspend flag.
// (R9) Host waits resume-to-suspend latency before suspending again.
// (R10) Resume is ignored in performance-enhance read mode.
// (R11) No-operation only cancels a pending reset arm.
// (R12) Commands taken as 8 serial clocks or 2 quad clocks.
// (R13) Reset acts only right after reset arm; other commands disarm.
// (R14) Software reset returns to standby with power-on defaults.
// (R15) Software reset aborts a running program or erase.
// (R16) Recovery time after reset depends on the interrupted activity.
// (R17) Parameter read takes three address bytes, one dummy, streams bytes; the code streams them only when quad command mode is off.
// (R18) Reset pin low for the minimum width resets the device.
// (R19) After pin reset: standby, volatile bits at defaults.
// (R20) Pin reset ends program or erase, output off throughout.
// (R21) Host keeps select high after reset release and after power-on.
// (R22) Power-up enters standby with the latch cleared.
// (R23) Suspend flags readable at bits 2 and 3 of security byte.
// (R24) Recovery times are cycle counters from the clock rate.
`timescale 1ns/1ps
`default_nettype none

module fsrrc_ctrl #(
    parameter int PROG_REC_CYC = fsrrc_pkg::PROG_REC_CYC,
    parameter int SECTOR_REC_CYC = fsrrc_pkg::SECTOR_REC_CYC,
    parameter int BLOCK_REC_CYC = fsrrc_pkg::BLOCK_REC_CYC,
    parameter int CHIP_REC_CYC = fsrrc_pkg::CHIP_REC_CYC,
    parameter int STATUS_REC_CYC = fsrrc_pkg::STATUS_REC_CYC
) (
    input wire logic sys_clk_in,                        // System clock
    input wire logic nrst_in,                           // Async reset, low
    input wire logic ce_in,                             // Clock enable
    input wire logic sclk_in,                           // Serial clock pin
    input wire logic cs_n_in,                           // Chip select pin, low
    input wire logic [3:0] sio_in,                      // Data lines in
    input wire logic reset_n_pin_in,                    // Reset pin, low
    input wire logic quad_command_mode_in,              // Quad command mode
    input wire logic perf_mode_in,                      // Enhance read mode
    input wire logic op_start_in,                       // Operation request
    input wire fsrrc_pkg::fsrrc_op_t op_kind_in,        // Requested kind
    input wire logic op_done_in,                        // Array finished
    input wire logic suspend_in,                        // Suspend request
    input wire logic erase_hit_in,                      // Address in erased region
    input wire logic protected_in,                      // Address protected
    input wire logic [7:0] param_data_in,               // Table byte
    output logic so_out,                                // Serial out
    output logic so_oe_out,                             // Serial out enable
    output logic [23:0] param_addr_out,                 // Table address
    output fsrrc_pkg::fsrrc_flags_t flags_out,          // Status flags
    output logic [7:0] security_out,                    // Security byte
    output logic ready_out,                             // Not in recovery
    output logic op_grant_out,                          // Operation started
    output logic abort_out,                             // Operation aborted
    output logic sw_reset_out                           // Software reset done
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edges
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] rstp_s;
    logic [3:0] sio_s1;
    logic [3:0] sio_s2;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_s <= 3'h0;
            cs_s <= 3'h7;
            rstp_s <= 2'h3;
            sio_s1 <= 4'h0;
            sio_s2 <= 4'h0;
        end else if (ce_in) begin
            sclk_s <= {sclk_s[1:0], sclk_in};
            cs_s <= {cs_s[1:0], cs_n_in};
            rstp_s <= {rstp_s[0], reset_n_pin_in};
            sio_s1 <= sio_in;
            sio_s2 <= sio_s1;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_low;
    logic cs_rise;
    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall = ~sclk_s[1] & sclk_s[2];
    assign cs_low = ~cs_s[1];
    assign cs_rise = cs_s[1] & ~cs_s[2];

    ////////////////////////////////////////////////////////////////////////
    // Command shifter
    logic [23:0] sh;
    logic [5:0] bits;
    logic [7:0] opcode;
    logic [23:0] next_sh;
    logic [5:0] next_bits;

    always_comb begin
        next_sh = quad_command_mode_in ? {sh[19:0], sio_s2} : {sh[22:0], sio_s2[0]}; // see (R12)
        next_bits = bits + (quad_command_mode_in ? fsrrc_pkg::STEP_QUAD
                                                 : fsrrc_pkg::STEP_SERIAL);
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sh <= 24'h0;
            bits <= 6'h0;
            opcode <= 8'h0;
        end else if (ce_in) begin
            if (!cs_low) begin
                bits <= 6'h0;
            end else if (sclk_rise && bits < fsrrc_pkg::BITS_DATA) begin
                sh <= next_sh;
                bits <= next_bits;
                if (next_bits == fsrrc_pkg::BITS_OPCODE) begin
                    opcode <= next_sh[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset pin, recovery counter, reset arm
    logic [7:0] low_cnt;
    logic hold;
    logic hw_evt;
    logic sw_evt;
    logic rst_evt;
    logic ready_i;
    logic exec;
    logic frame_done;
    logic arm;
    logic param_phase;
    fsrrc_pkg::fsrrc_rec_t rec;
    fsrrc_pkg::fsrrc_state_t state;
    fsrrc_pkg::fsrrc_op_t erase_kind;
    fsrrc_pkg::fsrrc_flags_t flags;

    assign hold = (low_cnt == fsrrc_pkg::RST_LOW_CYC);
    assign hw_evt = ce_in && !rstp_s[1] && (low_cnt == fsrrc_pkg::RST_LOW_CYC - 8'h01); // see (R18)
    assign ready_i = (rec == '0) && !hold;
    assign frame_done = ce_in && cs_rise && ready_i && (bits >= fsrrc_pkg::BITS_OPCODE);
    assign exec = frame_done && (bits == fsrrc_pkg::BITS_OPCODE);
    assign sw_evt = exec && (opcode == fsrrc_pkg::CMD_RESET) && arm; // see (R13)
    assign rst_evt = hw_evt || sw_evt;
    assign param_phase = cs_low && (opcode == fsrrc_pkg::CMD_PARAM_READ)
                         && (bits == fsrrc_pkg::BITS_DATA) && !quad_command_mode_in;

    function automatic fsrrc_pkg::fsrrc_rec_t rec_sel(input fsrrc_pkg::fsrrc_state_t st,
                                                      input fsrrc_pkg::fsrrc_op_t ek,
                                                      input logic reading);
        case (st)
            fsrrc_pkg::ST_PROG, fsrrc_pkg::ST_PP_ES: rec_sel = fsrrc_pkg::fsrrc_rec_t'(PROG_REC_CYC);
            fsrrc_pkg::ST_STATUS: rec_sel = fsrrc_pkg::fsrrc_rec_t'(STATUS_REC_CYC);
            fsrrc_pkg::ST_ERASE: begin
                case (ek)
                    fsrrc_pkg::OP_SECTOR: rec_sel = fsrrc_pkg::fsrrc_rec_t'(SECTOR_REC_CYC);
                    fsrrc_pkg::OP_BLOCK: rec_sel = fsrrc_pkg::fsrrc_rec_t'(BLOCK_REC_CYC);
                    default: rec_sel = fsrrc_pkg::fsrrc_rec_t'(CHIP_REC_CYC);
                endcase
            end
            default: rec_sel = reading ? fsrrc_pkg::READ_REC_CYC : fsrrc_pkg::DECODE_REC_CYC;
        endcase
    endfunction

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_cnt <= 8'h0;
        end else if (ce_in) begin
            if (rstp_s[1]) begin
                low_cnt <= 8'h0;
            end else if (!hold) begin
                low_cnt <= low_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rec <= fsrrc_pkg::POR_REC_CYC; // see (R22)
            ready_out <= 1'b0;
        end else if (ce_in) begin
            if (rst_evt) begin
                rec <= rec_sel(state, erase_kind, param_phase); // see (R16) (R24)
            end else if (!hold && rec != '0) begin
                rec <= rec - fsrrc_pkg::fsrrc_rec_t'(1);
            end
            ready_out <= ready_i && !rst_evt;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            arm <= 1'b0;
        end else if (ce_in) begin
            if (rst_evt) begin
                arm <= 1'b0;
            end else if (frame_done) begin
                arm <= exec && (opcode == fsrrc_pkg::CMD_RESET_ARM); // see (R11) (R13) (R1)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and flags
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= fsrrc_pkg::ST_IDLE;
            erase_kind <= fsrrc_pkg::OP_SECTOR;
            flags <= fsrrc_pkg::FLAGS_RESET; // see (R22)
            op_grant_out <= 1'b0;
            abort_out <= 1'b0;
            sw_reset_out <= 1'b0;
        end else if (ce_in) begin
            op_grant_out <= 1'b0;
            abort_out <= 1'b0;
            sw_reset_out <= 1'b0;
            if (rst_evt || hold) begin
                abort_out <= rst_evt && flags.busy_flag; // see (R15) (R20)
                sw_reset_out <= sw_evt;
                state <= fsrrc_pkg::ST_IDLE; // see (R14) (R19)
                flags <= fsrrc_pkg::FLAGS_RESET;
            end else if (op_done_in && flags.busy_flag) begin
                flags.busy_flag <= 1'b0; // see (R5)
                flags.write_enable_latch <= 1'b0;
                state <= (state == fsrrc_pkg::ST_PP_ES) ? fsrrc_pkg::ST_ESUSP
                                                        : fsrrc_pkg::ST_IDLE;
            end else if (suspend_in && state == fsrrc_pkg::ST_PROG) begin
                state <= fsrrc_pkg::ST_PSUSP;
                flags.program_suspend_flag <= 1'b1;
                flags.busy_flag <= 1'b0;
                flags.write_enable_latch <= 1'b0;
            end else if (suspend_in && state == fsrrc_pkg::ST_ERASE
                         && erase_kind != fsrrc_pkg::OP_CHIP) begin
                state <= fsrrc_pkg::ST_ESUSP;
                flags.erase_suspend_flag <= 1'b1;
                flags.busy_flag <= 1'b0;
                flags.write_enable_latch <= 1'b0;
            end else if (exec) begin
                case (opcode)
                    fsrrc_pkg::CMD_WRITE_ENABLE: flags.write_enable_latch <= 1'b1;
                    fsrrc_pkg::CMD_WRITE_DISABLE: begin
                        if (!flags.busy_flag) begin
                            flags.write_enable_latch <= 1'b0; // see (R1)
                        end
                    end
                    fsrrc_pkg::CMD_RESUME_A, fsrrc_pkg::CMD_RESUME_B: begin
                        if (!perf_mode_in && state == fsrrc_pkg::ST_PSUSP) begin // see (R10)
                            state <= fsrrc_pkg::ST_PROG; // see (R6)
                            flags <= '{1'b0, 1'b0, 1'b1, 1'b1}; // see (R8)
                        end else if (!perf_mode_in && state == fsrrc_pkg::ST_ESUSP) begin
                            state <= fsrrc_pkg::ST_ERASE; // see (R6)
                            flags <= '{1'b0, 1'b0, 1'b1, 1'b1}; // see (R8)
                        end
                    end
                    default: ;
                endcase
            end else if (op_start_in && ready_i && flags.write_enable_latch
                         && !protected_in) begin // see (R3)
                if (op_kind_in == fsrrc_pkg::OP_PROG && state == fsrrc_pkg::ST_IDLE) begin
                    state <= fsrrc_pkg::ST_PROG;
                    flags.busy_flag <= 1'b1;
                    op_grant_out <= 1'b1;
                end else if (op_kind_in == fsrrc_pkg::OP_PROG
                             && state == fsrrc_pkg::ST_ESUSP && !erase_hit_in) begin
                    state <= fsrrc_pkg::ST_PP_ES; // see (R2)
                    flags.busy_flag <= 1'b1;
                    op_grant_out <= 1'b1;
                end else if (op_kind_in != fsrrc_pkg::OP_PROG
                             && state == fsrrc_pkg::ST_IDLE) begin
                    state <= (op_kind_in == fsrrc_pkg::OP_STATUS) ? fsrrc_pkg::ST_STATUS
                                                                  : fsrrc_pkg::ST_ERASE;
                    erase_kind <= op_kind_in;
                    flags.busy_flag <= 1'b1;
                    op_grant_out <= 1'b1;
                end
            end
        end
    end

    assign flags_out = flags;

    always_comb begin
        security_out = 8'h00;
        security_out[fsrrc_pkg::SEC_PSB_BIT] = flags.program_suspend_flag; // see (R23)
        security_out[fsrrc_pkg::SEC_ESB_BIT] = flags.erase_suspend_flag;
    end

    ////////////////////////////////////////////////////////////////////////
    // Parameter table read out
    logic [6:0] pdata;
    logic [2:0] ocnt;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pdata <= 7'h0;
            ocnt <= 3'h0;
            so_out <= 1'b0;
            so_oe_out <= 1'b0;
            param_addr_out <= 24'h0;
        end else if (ce_in) begin
            so_oe_out <= param_phase && rstp_s[1] && ready_i; // see (R20) (R17)
            if (!cs_low) begin
                ocnt <= 3'h0;
            end else if (sclk_rise && next_bits == fsrrc_pkg::BITS_ADDR_END
                         && opcode == fsrrc_pkg::CMD_PARAM_READ) begin
                param_addr_out <= next_sh; // see (R17)
            end else if (sclk_fall && param_phase) begin
                ocnt <= ocnt + 3'h1;
                if (ocnt == 3'h0) begin
                    so_out <= param_data_in[7];
                    pdata <= param_data_in[6:0];
                    param_addr_out <= param_addr_out + 24'h1;
                end else begin
                    so_out <= pdata[6];
                    pdata <= {pdata[5:0], 1'b0};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking chk_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);

    resume_flags_a: assert property ( // see (R8)
        (exec && !rst_evt && !op_done_in && !suspend_in && !perf_mode_in
         && (opcode == fsrrc_pkg::CMD_RESUME_A || opcode == fsrrc_pkg::CMD_RESUME_B)
         && (state == fsrrc_pkg::ST_PSUSP || state == fsrrc_pkg::ST_ESUSP))
        |=> flags == 4'h3)
        else $error("resume did not set latch and busy");
    resume_perf_a: assert property ( // see (R10)
        (exec && perf_mode_in && state == fsrrc_pkg::ST_ESUSP && !rst_evt)
        |=> state == fsrrc_pkg::ST_ESUSP)
        else $error("resume taken in enhance mode");
    pp_es_flags_a: assert property ( // see (R5)
        state == fsrrc_pkg::ST_PP_ES |-> flags.write_enable_latch && flags.busy_flag)
        else $error("program in suspend lost latch or busy");
    pp_es_done_a: assert property ( // see (R5)
        (ce_in && state == fsrrc_pkg::ST_PP_ES && op_done_in && !rst_evt && !hold)
        |=> !flags.busy_flag && !flags.write_enable_latch && state == fsrrc_pkg::ST_ESUSP)
        else $error("program in suspend did not finish cleanly");
    pp_es_nosusp_a: assert property ( // see (R4)
        (ce_in && state == fsrrc_pkg::ST_PP_ES && suspend_in && !op_done_in && !rst_evt)
        |=> state == fsrrc_pkg::ST_PP_ES)
        else $error("program in suspend was suspended");
    pp_region_a: assert property ( // see (R2)
        (ce_in && state == fsrrc_pkg::ST_ESUSP && op_start_in && erase_hit_in)
        |=> state != fsrrc_pkg::ST_PP_ES)
        else $error("program granted inside suspended erase");
    nop_disarm_a: assert property ( // see (R11)
        (exec && opcode == fsrrc_pkg::CMD_NOP) |=> !arm)
        else $error("no-operation left reset armed");
    reset_unarmed_a: assert property ( // see (R13)
        (exec && opcode == fsrrc_pkg::CMD_RESET && !arm && !hw_evt) |=> !sw_reset_out)
        else $error("reset without arm");
    reset_default_a: assert property ( // see (R14)
        sw_evt |=> sw_reset_out && flags == fsrrc_pkg::FLAGS_RESET
                   && state == fsrrc_pkg::ST_IDLE && !ready_out)
        else $error("software reset left state");
    pin_hiz_a: assert property ( // see (R20)
        (ce_in && !rstp_s[1]) |=> !so_oe_out)
        else $error("output driven during pin reset");
    recovery_a: assert property ( // see (R16)
        (rst_evt && state == fsrrc_pkg::ST_PROG) |=> !ready_out ##0 rec > 22'h0)
        else $error("no recovery after reset");

endmodule // fsrrc_ctrl

`default_nettype wire

// [verification/fsrrc_host.sv]
`timescale 1ns/1ps
`default_nettype none

module fsrrc_host (
    input wire logic clk_in,        // System clock
    input wire logic quad_in,       // Quad command mode
    input wire logic so_in,         // Device serial out
    output logic sclk_out,          // Link clock
    output logic cs_n_out,          // Chip select, low
    output logic [3:0] sio_out,     // Data lines
    output logic [15:0] rx_out      // Bits read back
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sio_out = 4'h5;
        rx_out = 16'h0;
    end

    // Link clock stands low between frames, 320 ns per link clock period
    task automatic xfer(input logic [39:0] d, input int nb, input int nrx);
        int step;
        step = quad_in ? 4 : 1;
        cs_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < nb + nrx; i += step) begin
            // Upper lines toggle in serial mode
            sio_out <= quad_in ? d[39 -: 4] : {~sio_out[3:1], d[39]};
            d = d << step;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b1;
            if (i >= nb) begin
                rx_out <= {rx_out[14:0], so_in};
            end
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b1;
        sio_out <= ~sio_out;
        repeat (8) @(posedge clk_in);
    endtask
endmodule // fsrrc_host

`default_nettype wire

// [verification/fsrrc_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module fsrrc_ctrl_tb;
    logic clk = 1'b0, nrst = 1'b0, rst_pin = 1'b1, quad = 1'b0, perf = 1'b0;
    logic start = 1'b0, done = 1'b0, susp = 1'b0, hit = 1'b0, prot = 1'b0;
    logic ce = 1'b1;
    fsrrc_pkg::fsrrc_op_t kind = fsrrc_pkg::OP_PROG;
    logic sclk, cs_n, so, so_oe, ready, grant, abort_p, swr;
    logic [3:0] sio;
    logic [23:0] paddr;
    logic [7:0] sec;
    logic [15:0] rx;
    fsrrc_pkg::fsrrc_flags_t flags;
    int n_fail = 0;
    int check_count = 0;
    int n_abort = 0;
    int n_swr = 0;

    fsrrc_ctrl #(.PROG_REC_CYC(20), .SECTOR_REC_CYC(20), .BLOCK_REC_CYC(20),
        .CHIP_REC_CYC(20), .STATUS_REC_CYC(20)) dut (
        .sys_clk_in(clk), .nrst_in(nrst), .ce_in(ce), .sclk_in(sclk), .cs_n_in(cs_n),
        .sio_in(sio), .reset_n_pin_in(rst_pin), .quad_command_mode_in(quad),
        .perf_mode_in(perf), .op_start_in(start), .op_kind_in(kind), .op_done_in(done),
        .suspend_in(susp), .erase_hit_in(hit), .protected_in(prot),
        .param_data_in(paddr[7:0] ^ 8'hA5), .so_out(so), .so_oe_out(so_oe),
        .param_addr_out(paddr), .flags_out(flags), .security_out(sec), .ready_out(ready),
        .op_grant_out(grant), .abort_out(abort_p), .sw_reset_out(swr));

    // Released output line reads as the inverse of the last driven bit
    fsrrc_host host (.clk_in(clk), .quad_in(quad), .so_in(so_oe ? so : ~so), .sclk_out(sclk),
        .cs_n_out(cs_n), .sio_out(sio), .rx_out(rx));

    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (abort_p === 1'b1) n_abort++;
        if (swr === 1'b1) n_swr++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wait_ready();
        for (int k = 0; k < 5000 && ready !== 1'b1; k++) @(posedge clk);
        chk(ready, 1'b1);
        if (ready !== 1'b1) test_done();
    endtask

    task automatic cmd(input logic [7:0] c);
        host.xfer({c, 32'h0}, 8, 0);
    endtask

    task automatic op(input fsrrc_pkg::fsrrc_op_t k, input logic h, input logic p,
        input logic g);
        kind <= k;
        hit <= h;
        prot <= p;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        chk(grant, g);
    endtask

    task automatic ev(input logic s, input logic d);
        susp <= s;
        done <= d;
        @(posedge clk);
        susp <= 1'b0;
        done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_prog_suspend();
        cmd(fsrrc_pkg::CMD_WRITE_ENABLE);
        op(fsrrc_pkg::OP_PROG, 1'b0, 1'b0, 1'b1);
        chk(flags, 4'h3);
        ev(1'b1, 1'b0);
        chk(sec, 8'h04);
        cmd(8'h05);
        cmd(fsrrc_pkg::CMD_RESET_ARM);
        cmd(fsrrc_pkg::CMD_NOP);
        cmd(fsrrc_pkg::CMD_RESET);
        chk(n_swr, 0);
        chk(flags, 4'h4);
        cmd(fsrrc_pkg::CMD_RESUME_A);
        chk(flags, 4'h3);
        repeat (8) @(posedge clk);
        ev(1'b1, 1'b0);
        chk(flags, 4'h4);
        cmd(fsrrc_pkg::CMD_RESUME_A);
        chk(flags, 4'h3);
        ev(1'b0, 1'b1);
        chk(flags, 4'h0);
    endtask

    task automatic t_freeze_chip();
        cmd(fsrrc_pkg::CMD_WRITE_ENABLE);
        ce <= 1'b0;
        op(fsrrc_pkg::OP_CHIP, 1'b0, 1'b0, 1'b0);
        chk(flags, 4'h2);
        ce <= 1'b1;
        cmd(fsrrc_pkg::CMD_WRITE_DISABLE);
        chk(flags, 4'h0);
        cmd(fsrrc_pkg::CMD_WRITE_ENABLE);
        op(fsrrc_pkg::OP_CHIP, 1'b0, 1'b0, 1'b1);
        ev(1'b1, 1'b0);
        chk(flags, 4'h3);
        ev(1'b0, 1'b1);
        chk(flags, 4'h0);
    endtask

    task automatic t_erase_program();
        cmd(fsrrc_pkg::CMD_WRITE_ENABLE);
        op(fsrrc_pkg::OP_SECTOR, 1'b0, 1'b0, 1'b1);
        ev(1'b1, 1'b0);
        chk(sec, 8'h08);
        cmd(fsrrc_pkg::CMD_WRITE_ENABLE);
        op(fsrrc_pkg::OP_PROG, 1'b1, 1'b0, 1'b0);
        op(fsrrc_pkg::OP_PROG, 1'b0, 1'b1, 1'b0);
        op(fsrrc_pkg::OP_PROG, 1'b0, 1'b0, 1'b1);
        chk(flags, 4'hB);
        ev(1'b1, 1'b0);
        chk(flags, 4'hB);
        ev(1'b0, 1'b1);
        chk(flags, 4'h8);
        perf <= 1'b1;
        cmd(fsrrc_pkg::CMD_RESUME_B);
        chk(flags, 4'h8);
        perf <= 1'b0;
        cmd(fsrrc_pkg::CMD_RESUME_B);
        chk(flags, 4'h3);
        quad <= 1'b1;
        @(posedge clk);
        cmd(fsrrc_pkg::CMD_RESET_ARM);
        cmd(fsrrc_pkg::CMD_RESET);
        chk(n_swr, 1);
        chk(n_abort, 1);
        chk(flags, 4'h0);
        chk(ready, 1'b0);
        quad <= 1'b0;
        wait_ready();
    endtask

    task automatic t_param_read();
        host.xfer({fsrrc_pkg::CMD_PARAM_READ, 24'h000010, 8'h00}, 40, 16);
        chk(rx, {8'h10 ^ 8'hA5, 8'h11 ^ 8'hA5});
        chk(so_oe, 1'b0);
    endtask

    task automatic t_pin_reset();
        cmd(fsrrc_pkg::CMD_WRITE_ENABLE);
        op(fsrrc_pkg::OP_PROG, 1'b0, 1'b0, 1'b1);
        rst_pin <= 1'b0;
        repeat (300) @(posedge clk);
        chk(so_oe, 1'b0);
        chk(ready, 1'b0);
        chk(n_abort, 2);
        rst_pin <= 1'b1;
        repeat (2) @(posedge clk);
        wait_ready();
        chk(flags, 4'h0);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(flags, 4'h0);
        wait_ready();
        t_prog_suspend();
        t_erase_program();
        t_param_read();
        t_freeze_chip();
        t_pin_reset();
        test_done();
    end
endmodule // fsrrc_ctrl_tb

`default_nettype wire
